/* core/lcr_top.sv */
// Link capabilities register of one switch port
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
module lcr_top (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [lcr_pkg::LCR_PORT_W-1:0] port_id,
	input wire logic [lcr_pkg::LCR_ADDR_W-1:0] reg_addr,
	input wire logic [lcr_pkg::LCR_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [lcr_pkg::LCR_DATA_W-1:0] reg_rdata,
	input wire logic lock_open,
	input wire logic preload_we,
	input wire logic [lcr_pkg::LCR_DATA_W-1:0] preload_data,
	input wire logic link_up,
	output logic link_active_rpt,
	output logic [lcr_pkg::LCR_DATA_W-1:0] cap_word,
	output logic cfg_ready
);
	import lcr_pkg::*;

	typedef struct packed {
		lcr_state_t st;
		logic [LCR_DATA_W-1:0] rdata;
		logic [LCR_DATA_W-1:0] capw;
		logic lact;
	} lcr_top_t;

	lcr_top_t r;
	lcr_top_t n;

	logic [LCR_PORT_W-1:0] s_id;
	logic s_done;
	logic s_ups;
	logic init_ld;
	logic wr_hit;
	logic wr_ok;
	logic pre_ok;
	logic pp_zero;
	logic [LCR_PP_W-1:0] pp_init;
	logic [LCR_WID_W-1:0] wid_q;
	logic [LCR_ASPM_W-1:0] aspm_q;
	logic [LCR_L0S_W-1:0] l0s_q;
	logic [LCR_L1_W-1:0] l1_q;
	logic [0:0] rck_q;
	logic [LCR_PP_W-1:0] pp_q;
	logic [LCR_DATA_W-1:0] cap_cur;

	// Identity pin is sampled by a clocked stage, never by the reset
	lcr_strap u_strap (
		.core_clk(core_clk),
		.rst(rst),
		.port_id(port_id),
		.id(s_id),
		.done(s_done),
		.upstream(s_ups)
	);

	// Access qualifiers; nothing lockable moves before defaults are in
	assign init_ld = (r.st == LCR_ST_INIT) && s_done;
	assign wr_hit = reg_wr && (reg_addr == LCR_LCAP_OFF);
	assign wr_ok = wr_hit && lock_open && (r.st == LCR_ST_RUN);
	assign pre_ok = preload_we && (r.st == LCR_ST_RUN);
	// Upstream port keeps its per-port bits at zero whatever is written
	assign pp_zero = s_done && s_ups;
	assign pp_init = s_ups ? LCR_PP_UP_RST : LCR_PP_DN_RST;

	lcr_lockfld #(
		.W(LCR_WID_W),
		.RST(LCR_WID_RST)
	) u_wid (
		.core_clk(core_clk),
		.rst(rst),
		.init_ld(init_ld),
		.init_val(LCR_WID_RST),
		.pre_we(pre_ok),
		.pre_val(preload_data[LCR_WID_LSB +: LCR_WID_W]),
		.wr_ok(wr_ok),
		.wr_val(reg_wdata[LCR_WID_LSB +: LCR_WID_W]),
		.zero_hold(1'b0),
		.q(wid_q)
	);

	lcr_lockfld #(
		.W(LCR_ASPM_W),
		.RST(LCR_ASPM_RST)
	) u_aspm (
		.core_clk(core_clk),
		.rst(rst),
		.init_ld(init_ld),
		.init_val(LCR_ASPM_RST),
		.pre_we(pre_ok),
		.pre_val(preload_data[LCR_ASPM_LSB +: LCR_ASPM_W]),
		.wr_ok(wr_ok),
		.wr_val(reg_wdata[LCR_ASPM_LSB +: LCR_ASPM_W]),
		.zero_hold(1'b0),
		.q(aspm_q)
	);

	lcr_lockfld #(
		.W(LCR_L0S_W),
		.RST(LCR_L0S_RST)
	) u_l0s (
		.core_clk(core_clk),
		.rst(rst),
		.init_ld(init_ld),
		.init_val(LCR_L0S_RST),
		.pre_we(pre_ok),
		.pre_val(preload_data[LCR_L0S_LSB +: LCR_L0S_W]),
		.wr_ok(wr_ok),
		.wr_val(reg_wdata[LCR_L0S_LSB +: LCR_L0S_W]),
		.zero_hold(1'b0),
		.q(l0s_q)
	);

	// Code 2 covers the fixed deep idle exit time of the link
	lcr_lockfld #(
		.W(LCR_L1_W),
		.RST(LCR_L1_RST)
	) u_l1 (
		.core_clk(core_clk),
		.rst(rst),
		.init_ld(init_ld),
		.init_val(LCR_L1_RST),
		.pre_we(pre_ok),
		.pre_val(preload_data[LCR_L1_LSB +: LCR_L1_W]),
		.wr_ok(wr_ok),
		.wr_val(reg_wdata[LCR_L1_LSB +: LCR_L1_W]),
		.zero_hold(1'b0),
		.q(l1_q)
	);

	lcr_lockfld #(
		.W(1),
		.RST(LCR_RCK_RST)
	) u_rck (
		.core_clk(core_clk),
		.rst(rst),
		.init_ld(init_ld),
		.init_val(LCR_RCK_RST),
		.pre_we(pre_ok),
		.pre_val(preload_data[LCR_RCK_BIT]),
		.wr_ok(wr_ok),
		.wr_val(reg_wdata[LCR_RCK_BIT]),
		.zero_hold(1'b0),
		.q(rck_q)
	);

	// Surprise-down, link-active and bandwidth bits share one field
	lcr_lockfld #(
		.W(LCR_PP_W),
		.RST(LCR_PP_UP_RST)
	) u_pp (
		.core_clk(core_clk),
		.rst(rst),
		.init_ld(init_ld),
		.init_val(pp_init),
		.pre_we(pre_ok),
		.pre_val(preload_data[LCR_PP_LSB +: LCR_PP_W]),
		.wr_ok(wr_ok),
		.wr_val(reg_wdata[LCR_PP_LSB +: LCR_PP_W]),
		.zero_hold(pp_zero),
		.q(pp_q)
	);

	// Assemble the word; read-only parts are constants or strap copies
	always_comb
	begin
		cap_cur = 32'h00000000;
		cap_cur[LCR_SPD_LSB +: LCR_SPD_W] = LCR_SPD_RST;
		cap_cur[LCR_WID_LSB +: LCR_WID_W] = wid_q;
		cap_cur[LCR_ASPM_LSB +: LCR_ASPM_W] = aspm_q;
		cap_cur[LCR_L0S_LSB +: LCR_L0S_W] = l0s_q;
		cap_cur[LCR_L1_LSB +: LCR_L1_W] = l1_q;
		cap_cur[LCR_RCK_BIT] = rck_q[0];
		cap_cur[LCR_PP_LSB +: LCR_PP_W] = pp_q;
		cap_cur[LCR_RSV_LSB +: LCR_RSV_W] = LCR_RSV_VAL;
		cap_cur[LCR_PORT_LSB +: LCR_PORTF_W] = {6'h00, s_id};
	end

	// Sequencer, read port and status copies
	always_comb
	begin
		n = r;
		case (r.st)
			LCR_ST_INIT:
			begin
				if (s_done)
					n.st = LCR_ST_RUN;
			end
			LCR_ST_RUN:
				n.st = LCR_ST_RUN;
			default:
				n.st = LCR_ST_INIT;
		endcase
		// Read data stands for one cycle; unmapped reads return zero
		n.rdata = 32'h00000000;
		if (reg_rd)
		begin
			if (reg_addr == LCR_LCAP_OFF)
				n.rdata = cap_cur;
			else
				n.rdata = 32'h00000000;
		end
		n.capw = cap_cur;
		// Status follows the link whatever the advertised bit says
		n.lact = link_up;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			r <= '{st: LCR_ST_INIT, rdata: 32'h00000000, capw: 32'h00000000, lact: 1'b0};
		else
			r <= n;
	end

	// All outputs are flop copies
	assign reg_rdata = r.rdata;
	assign cap_word = r.capw;
	assign link_active_rpt = r.lact;
	assign cfg_ready = r.st[1];

	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	sequence s_init;
		init_ld;
	endsequence

	sequence s_rd_hit;
		reg_rd && (reg_addr == LCR_LCAP_OFF);
	endsequence

	sequence s_locked_wr;
		cfg_ready && wr_hit && !lock_open && !preload_we;
	endsequence

	property p_speed;
		cap_word[LCR_SPD_LSB +: LCR_SPD_W] == 4'h2 || !cfg_ready;
	endproperty
	a_speed: assert property (p_speed) else $error("speed field not 2");

	property p_width;
		s_init |=> cap_cur[LCR_WID_LSB +: LCR_WID_W] == 6'h04 ##1 cap_word[9:4] == 6'h04;
	endproperty
	a_width: assert property (p_width) else $error("width default not 4");

	property p_aspm;
		s_init |=> cap_cur[11:10] == 2'h3;
	endproperty
	a_aspm: assert property (p_aspm) else $error("idle support default not 3");

	property p_l0s;
		s_init |=> cap_cur[14:12] == 3'h6;
	endproperty
	a_l0s: assert property (p_l0s) else $error("short idle latency default not 6");

	property p_l1;
		s_init |=> cap_cur[17:15] == 3'h2;
	endproperty
	a_l1: assert property (p_l1) else $error("deep idle latency default not 2");

	property p_rck;
		s_init |=> !cap_cur[18];
	endproperty
	a_rck: assert property (p_rck) else $error("clock removal default not 0");

	property p_up_zero;
		(s_done && s_ups) |-> cap_cur[21:19] == 3'h0;
	endproperty
	a_up_zero: assert property (p_up_zero) else $error("upstream per-port bit set");

	property p_lact;
		(link_up && !cap_cur[LCR_LAR_BIT]) |=> link_active_rpt;
	endproperty
	a_lact: assert property (p_lact) else $error("link active status gated by cap bit");

	property p_dn_init;
		(s_init and (!s_ups)) |=> cap_cur[21:19] == 3'h7;
	endproperty
	a_dn_init: assert property (p_dn_init) else $error("downstream per-port bits not set");

	property p_port;
		cfg_ready |-> cap_word[31:24] == {6'h00, s_id};
	endproperty
	a_port: assert property (p_port) else $error("port index field wrong");

	property p_locked;
		s_locked_wr |=> $stable(cap_cur);
	endproperty
	a_locked: assert property (p_locked) else $error("locked write changed the word");

	property p_rsvd;
		cap_cur[23:22] == 2'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

	property p_strap;
		$rose(s_done) |-> s_id == $past(port_id) ##1 (r.st == LCR_ST_RUN);
	endproperty
	a_strap: assert property (p_strap) else $error("port identity not captured");

	property p_rd;
		s_rd_hit |=> reg_rdata == $past(cap_cur);
	endproperty
	a_rd: assert property (p_rd) else $error("read data wrong");

	// Unlocked writes and preloads must really land, or the lock checks prove nothing
	sequence s_open_wr;
		cfg_ready && wr_ok && !preload_we;
	endsequence

	sequence s_preload;
		cfg_ready && pre_ok;
	endsequence

	property p_open_wid;
		s_open_wr |=> cap_cur[LCR_WID_LSB +: LCR_WID_W] == $past(reg_wdata[LCR_WID_LSB +: LCR_WID_W]);
	endproperty
	a_open_wid: assert property (p_open_wid) else $error("unlocked width write lost");

	property p_open_rck;
		s_open_wr |=> cap_cur[LCR_RCK_BIT] == $past(reg_wdata[LCR_RCK_BIT]);
	endproperty
	a_open_rck: assert property (p_open_rck) else $error("unlocked clock removal write lost");

	property p_pre_l0s;
		s_preload |=> cap_cur[LCR_L0S_LSB +: LCR_L0S_W] == $past(preload_data[LCR_L0S_LSB +: LCR_L0S_W]);
	endproperty
	a_pre_l0s: assert property (p_pre_l0s) else $error("preload of short idle latency lost");

	property p_pre_dn;
		(s_preload and (!s_ups)) |=> cap_cur[LCR_PP_LSB +: LCR_PP_W] == $past(preload_data[LCR_PP_LSB +: LCR_PP_W]);
	endproperty
	a_pre_dn: assert property (p_pre_dn) else $error("downstream per-port preload lost");

	// Read port is quiet between reads
	property p_rd_idle;
		!reg_rd |=> reg_rdata == 32'h00000000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");

	property p_capw;
		1'b1 |=> cap_word == $past(cap_cur);
	endproperty
	a_capw: assert property (p_capw) else $error("word copy lags wrongly");

	property p_lact_fol;
		1'b1 |=> link_active_rpt == $past(link_up);
	endproperty
	a_lact_fol: assert property (p_lact_fol) else $error("link active status not following link");

	// Only a reset may take the defaults away again
	property p_ready;
		cfg_ready |=> cfg_ready;
	endproperty
	a_ready: assert property (p_ready) else $error("ready dropped without reset");
endmodule

/* inc/lcr_pkg.sv */
// Constants and types shared by the link capability register bank
package lcr_pkg;
	localparam int LCR_ADDR_W = 12;
	localparam int LCR_DATA_W = 32;
	localparam int LCR_PORT_W = 2;
	// Byte offset of the link capabilities word
	localparam logic [11:0] LCR_LCAP_OFF = 12'h04C;
	// Field positions and widths
	localparam int LCR_SPD_LSB = 0;
	localparam int LCR_SPD_W = 4;
	localparam int LCR_WID_LSB = 4;
	localparam int LCR_WID_W = 6;
	localparam int LCR_ASPM_LSB = 10;
	localparam int LCR_ASPM_W = 2;
	localparam int LCR_L0S_LSB = 12;
	localparam int LCR_L0S_W = 3;
	localparam int LCR_L1_LSB = 15;
	localparam int LCR_L1_W = 3;
	localparam int LCR_RCK_BIT = 18;
	localparam int LCR_PP_LSB = 19;
	localparam int LCR_PP_W = 3;
	localparam int LCR_SDN_BIT = 19;
	localparam int LCR_LAR_BIT = 20;
	localparam int LCR_BWN_BIT = 21;
	localparam int LCR_RSV_LSB = 22;
	localparam int LCR_RSV_W = 2;
	localparam int LCR_PORT_LSB = 24;
	localparam int LCR_PORTF_W = 8;
	// Values after reset
	localparam logic [3:0] LCR_SPD_RST = 4'h2;
	localparam logic [5:0] LCR_WID_RST = 6'h04;
	localparam logic [1:0] LCR_ASPM_RST = 2'h3;
	localparam logic [2:0] LCR_L0S_RST = 3'h6;
	localparam logic [2:0] LCR_L1_RST = 3'h2;
	localparam logic [0:0] LCR_RCK_RST = 1'h0;
	localparam logic [2:0] LCR_PP_DN_RST = 3'h7;
	localparam logic [2:0] LCR_PP_UP_RST = 3'h0;
	localparam logic [1:0] LCR_RSV_VAL = 2'h0;
	// Port index of the upstream port
	localparam logic [1:0] LCR_UPSTREAM_ID = 2'h0;
	// Deep idle exit time of the link and the span its latency code covers
	localparam real LCR_DEEP_EXIT_US = 2.3;
	localparam real LCR_L1_CODE_MIN_US = 2.0;
	localparam real LCR_L1_CODE_MAX_US = 4.0;
	typedef enum logic [1:0] {
		LCR_ST_INIT = 2'b01,
		LCR_ST_RUN = 2'b10
	} lcr_state_t;
endpackage

/* core/lcr_strap.sv */
// Captures the static port identity once after reset release
`timescale 1ns/1ns
module lcr_strap (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [lcr_pkg::LCR_PORT_W-1:0] port_id,
	output logic [lcr_pkg::LCR_PORT_W-1:0] id,
	output logic done,
	output logic upstream
);
	import lcr_pkg::*;

	typedef struct packed {
		logic done;
		logic ups;
		logic [LCR_PORT_W-1:0] id;
	} lcr_strap_t;

	lcr_strap_t r;
	lcr_strap_t n;

	// Sample once; the pin is static so later changes are ignored
	always_comb
	begin
		n = r;
		if (!r.done)
		begin
			n.done = 1'b1;
			n.id = port_id;
			n.ups = (port_id == LCR_UPSTREAM_ID);
		end
	end

	// Reset takes constants only, the pin is caught after release
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			r <= '{done: 1'b0, ups: 1'b0, id: 2'h0};
		else
			r <= n;
	end

	assign id = r.id;
	assign done = r.done;
	assign upstream = r.ups;
endmodule

/* core/lcr_lockfld.sv */
// One lockable capability field with default load, preload and gated write
`timescale 1ns/1ns
module lcr_lockfld #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = {W{1'b0}}
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic init_ld,
	input wire logic [W-1:0] init_val,
	input wire logic pre_we,
	input wire logic [W-1:0] pre_val,
	input wire logic wr_ok,
	input wire logic [W-1:0] wr_val,
	input wire logic zero_hold,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] val;
	} lcr_fld_t;

	lcr_fld_t r;
	lcr_fld_t n;

	// Forced zero beats everything, then defaults, preload, unlocked write
	always_comb
	begin
		n = r;
		if (zero_hold)
			n.val = {W{1'b0}};
		else if (init_ld)
			n.val = init_val;
		else if (pre_we)
			n.val = pre_val;
		else if (wr_ok)
			n.val = wr_val;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			r.val <= RST;
		else
			r <= n;
	end

	assign q = r.val;
endmodule

/* bench/lcr_tb_top.sv */
// Self-checking bench for the link capabilities register bank
`timescale 1ns/1ns
module lcr_tb_top;
	import lcr_pkg::*;
	logic core_clk, rst, reg_wr, reg_rd, lock_open, preload_we, link_up;
	logic link_active_rpt, cfg_ready, rd_seen, lk_seen, lk_ok, dn;
	logic [1:0] port_id;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, preload_data, reg_rdata, cap_word, exp_w, lockm;
	logic [31:0] exp_q[$];
	logic [31:0] vals [3];
	int errors, compares, seed, i;

	lcr_top dut_u (
		.core_clk(core_clk),
		.rst(rst),
		.port_id(port_id),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.lock_open(lock_open),
		.preload_we(preload_we),
		.preload_data(preload_data),
		.link_up(link_up),
		.link_active_rpt(link_active_rpt),
		.cap_word(cap_word),
		.cfg_ready(cfg_ready)
	);

	// 50 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task chk(input string what, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask

	task stop_test;
		if (errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Watchdog, far beyond the 150 or so cycles the run needs
	initial
	begin
		#100000;
		errors++;
		stop_test;
	end

	// Link state wanders randomly so the status path is exercised every cycle
	always @(posedge core_clk)
		link_up <= $random(seed);

	// Watches the outputs; read data is due exactly one cycle after the strobe
	always @(posedge core_clk)
	begin
		if (rd_seen === 1'b1)
			chk("reg_rdata", exp_q.pop_front(), reg_rdata);
		else if (rst === 1'b0)
			chk("reg_rdata idle", 32'h0, reg_rdata);
		if (lk_ok === 1'b1 && rst === 1'b0)
			chk("link_active_rpt", {31'h0, lk_seen}, {31'h0, link_active_rpt});
		rd_seen = reg_rd;
		lk_seen = link_up;
		lk_ok = !rst;
	end

	task idle;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		preload_we <= 1'b0;
		@(posedge core_clk);
	endtask

	task bus_rd(input logic [11:0] a);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(a == 12'h04C ? exp_w : 32'h0);
		@(posedge core_clk);
	endtask

	// Model keeps lockable bits only on an unlocked write to the mapped word
	task bus_wr(input logic [11:0] a, input logic [31:0] d, input logic lk);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
		lock_open <= lk;
		if (lk && a == 12'h04C)
			exp_w = (exp_w & ~lockm) | (d & lockm);
		@(posedge core_clk);
	endtask

	// Preload with a competing bus write in the same cycle; preload wins
	task pre_ld(input logic [31:0] p, input logic [31:0] d, input logic lk);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= 12'h04C;
		reg_wdata <= d;
		lock_open <= lk;
		preload_we <= 1'b1;
		preload_data <= p;
		exp_w = (exp_w & ~lockm) | (p & lockm);
		@(posedge core_clk);
	endtask

	task do_reset(input logic [1:0] p);
		int n;
		rst <= 1'b1;
		port_id <= p;
		idle;
		repeat (7) @(posedge core_clk);
		#1;
		chk("cap_word in reset", 32'h0, cap_word);
		chk("cfg_ready in reset", 32'h0, {31'h0, cfg_ready});
		rst <= 1'b0;
		dn = (p != 2'h0);
		lockm = dn ? 32'h003FFFF0 : 32'h0007FFF0;
		exp_w = (dn ? 32'h00396C42 : 32'h00016C42) | {6'h0, p, 24'h0};
		n = 0;
		while (cfg_ready !== 1'b1 && n < 10)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk("cfg_ready edge", 32'd2, n);
		@(posedge core_clk);
		@(posedge core_clk);
		#1;
	endtask

	initial
	begin
		seed = 32'hA02F02F0;
		errors = 0;
		compares = 0;
		rst = 1'b1;
		port_id = 2'h0;
		reg_addr = 12'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		lock_open = 1'b0;
		preload_we = 1'b0;
		preload_data = 32'h0;
		link_up = 1'b0;
		rd_seen = 1'b0;
		lk_seen = 1'b0;
		lk_ok = 1'b0;
		for (i = 0; i < 4; i++)
		begin
			do_reset(i[1:0]);
			// Defaults field by field
			chk("max_speed_field", 32'h2, cap_word[3:0]);
			chk("max_width_field", 32'h4, cap_word[9:4]);
			chk("idle_state_support", 32'h3, cap_word[11:10]);
			chk("short_idle_exit_latency", 32'h6, cap_word[14:12]);
			chk("deep_idle_exit_latency", 32'h2, cap_word[17:15]);
			chk("refclk_removal_support", 32'h0, cap_word[18]);
			chk("surprise_down_report_cap", {31'h0, dn}, cap_word[19]);
			chk("link_active_report_cap", {31'h0, dn}, cap_word[20]);
			chk("bandwidth_notify_cap", {31'h0, dn}, cap_word[21]);
			chk("reserved", 32'h0, cap_word[23:22]);
			chk("port_index", i, cap_word[31:24]);
			// Back-to-back reads, the second one unmapped
			bus_rd(12'h04C);
			bus_rd(12'h050);
			idle;
			vals = '{$random(seed), 32'hFFFFFFFF, 32'h0};
			foreach (vals[k])
			begin
				bus_wr(12'h04C, ~vals[k], 1'b0);
				bus_wr(12'h048, ~vals[k], 1'b1);
				bus_wr(12'h04C, vals[k], 1'b1);
				bus_rd(12'h04C);
				idle;
				#1;
				chk("cap_word after write", exp_w, cap_word);
			end
			// Preload ignores the lock, then beats a simultaneous write
			pre_ld($random(seed), $random(seed), 1'b0);
			idle;
			bus_rd(12'h04C);
			pre_ld($random(seed), $random(seed), 1'b1);
			idle;
			bus_rd(12'h04C);
			idle;
			#1;
			chk("cap_word after preload", exp_w, cap_word);
		end
		idle;
		idle;
		stop_test;
	end
endmodule
